// ==== rtl/tam_regs.svh ====
// Register offsets, field positions and reset values of the temperature alarm block
`ifndef TAM_REGS_SVH
`define TAM_REGS_SVH

// Byte offsets
`define TAM_ADDR_FLAGS 8'h00
`define TAM_ADDR_IRQ_EN 8'h02
`define TAM_ADDR_PIN_CFG 8'h12
`define TAM_ADDR_UPPER_HI 8'h22
`define TAM_ADDR_UPPER_LO 8'h23
`define TAM_ADDR_LOWER_HI 8'h24
`define TAM_ADDR_LOWER_LO 8'h25
`define TAM_ADDR_RISE 8'h26
`define TAM_ADDR_FALL 8'h27
`define TAM_ADDR_SLOPE_CFG 8'h28
`define TAM_ADDR_CONV_CTRL 8'h2A
`define TAM_ADDR_SLOPE_HI 8'h2D
`define TAM_ADDR_SLOPE_LO 8'h2E

// Field positions
`define TAM_BIT_HIGH 2
`define TAM_BIT_LOW 3
`define TAM_BIT_RISE 4
`define TAM_BIT_FALL 5
`define TAM_BIT_PIN_EN 7
`define TAM_BIT_DETECT_EN 3
`define TAM_BIT_AUTO 1
`define TAM_BIT_ALERT_MODE 2
`define TAM_WIN_MSB 2

// Reset values
`define TAM_UPPER_RST 16'h7FFF
`define TAM_LOWER_RST 16'h8000
`define TAM_BYTE_RST 8'h00
`define TAM_SLOPE_RST 9'h000

// Slope saturation bounds
`define TAM_SLOPE_MAX 17'h000FF
`define TAM_SLOPE_MIN 17'h1FF00

`endif

// ==== rtl/tam_pkg.sv ====
// Types shared by the temperature alarm block
package tam_pkg;

	// Byte register access from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tam_reg_req_t;

	// Finished conversion result
	typedef struct packed {
		logic valid;
		logic [15:0] temp;
	} tam_conv_t;

	// Alert behaviour
	typedef enum logic {
		TAM_ALERT_LATCH = 1'b0,
		TAM_ALERT_HYST = 1'b1
	} tam_alert_mode_t;

endpackage

// ==== rtl/tam_slope_monitor.sv ====
// Threshold and rate-of-change alarm logic with its byte register file
`timescale 1ns/100ps
`include "tam_regs.svh"

module tam_slope_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register access
	input wire tam_pkg::tam_reg_req_t reg_req_i,
	output logic [7:0] rd_data_o,
	// Conversion results
	input wire tam_pkg::tam_conv_t conv_i,
	// Interrupt to the host
	output logic irq_o
);
	import tam_pkg::*;

	// Window span N-1 for a window code
	function automatic logic [6:0] win_span(input logic [2:0] code);
		logic [6:0] s;
		s = 7'h40;
		if (code < 3'h6)
		begin
			s = 7'h01 << code;
		end
		return s;
	endfunction

	// Shift that divides by the span, spans are powers of two
	function automatic logic [2:0] win_shift(input logic [2:0] code);
		logic [2:0] s;
		s = code;
		if (code == 3'h7)
		begin
			s = 3'h6;
		end
		return s;
	endfunction

	// Address match for a strobe
	function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] b);
		return stb && (a == b);
	endfunction

	// Software registers
	logic [7:0] flags; // Sticky status
	logic [7:0] irq_en; // Interrupt enables
	logic [7:0] pin_cfg; // Pin trigger config
	logic [15:0] upper; // Upper limit
	logic [15:0] lower; // Lower limit
	logic [7:0] rise; // Rise slope limit
	logic [7:0] fall; // Fall slope limit
	logic [7:0] slope_cfg; // Detect enable and window
	logic [7:0] conv_ctrl; // Conversion control
	logic [8:0] slope; // Last slope

	// Sample history, 64 past results cover the widest window
	logic [15:0] hist [0:63];
	logic [5:0] wp; // Next history slot
	logic [6:0] fill; // Samples held, saturates at 64

	// Decoded controls
	tam_alert_mode_t alert_mode;
	wire roc_en;
	wire status_rd;
	wire signed [15:0] temp;
	wire above;
	wire below;
	assign alert_mode = tam_alert_mode_t'(conv_ctrl[`TAM_BIT_ALERT_MODE]);
	// Slope mode needs a trigger source as well as the detect bit
	assign roc_en = slope_cfg[`TAM_BIT_DETECT_EN]
		&& (conv_ctrl[`TAM_BIT_AUTO] || pin_cfg[`TAM_BIT_PIN_EN]);
	assign status_rd = hit(reg_req_i.rd, reg_req_i.addr, `TAM_ADDR_FLAGS);
	// Signed comparison of the new result with both limits
	assign temp = $signed(conv_i.temp);
	assign above = temp > $signed(upper);
	assign below = temp < $signed(lower);

	// Slope datapath
	wire [6:0] span;
	wire [2:0] shift;
	wire [15:0] oldest;
	wire enough;
	wire signed [16:0] diff;
	wire signed [16:0] scaled;
	wire [8:0] new_slope;
	wire slope_upd;
	wire rise_hit;
	wire fall_hit;
	assign span = win_span(slope_cfg[`TAM_WIN_MSB:0]);
	assign shift = win_shift(slope_cfg[`TAM_WIN_MSB:0]);
	// Span of 64 wraps to the slot about to be overwritten, the oldest one
	assign oldest = hist[wp - span[5:0]];
	assign enough = fill >= span;
	assign diff = $signed({temp[15], temp}) - $signed({oldest[15], oldest});
	assign scaled = diff >>> shift;
	// Saturate so a step larger than nine bits still trips the limits
	assign new_slope = (scaled > $signed(`TAM_SLOPE_MAX)) ? 9'h0FF :
		(scaled < $signed(`TAM_SLOPE_MIN)) ? 9'h100 : scaled[8:0];
	assign slope_upd = conv_i.valid && roc_en && enough;
	assign rise_hit = $signed(new_slope) > $signed({1'b0, rise});
	assign fall_hit = $signed({new_slope[8], new_slope})
		< -$signed({2'b00, fall});

	// Next status, a set in the clearing cycle wins
	wire high_set;
	wire low_set;
	wire next_high;
	wire next_low;
	wire next_rise;
	wire next_fall;
	wire [7:0] next_flags;
	wire next_irq;
	assign high_set = conv_i.valid && above;
	assign low_set = conv_i.valid && below;
	// Latched mode clears on read, hysteretic mode only on a low result
	assign next_high = (alert_mode == TAM_ALERT_LATCH)
		? (high_set || (flags[`TAM_BIT_HIGH] && !status_rd))
		: (high_set || (flags[`TAM_BIT_HIGH] && !low_set));
	assign next_low = (alert_mode == TAM_ALERT_LATCH)
		&& (low_set || (flags[`TAM_BIT_LOW] && !status_rd));
	assign next_rise = (slope_upd && rise_hit)
		|| (flags[`TAM_BIT_RISE] && !status_rd);
	assign next_fall = (slope_upd && fall_hit)
		|| (flags[`TAM_BIT_FALL] && !status_rd);
	assign next_flags = {2'b00, next_fall, next_rise, next_low, next_high, 2'b00};
	// Each flag reaches the pin only through its own enable
	assign next_irq = |(next_flags[`TAM_BIT_FALL:`TAM_BIT_HIGH]
		& irq_en[`TAM_BIT_FALL:`TAM_BIT_HIGH]);

	// Read mux, unmapped offsets read zero
	logic [7:0] next_rd;
	always_comb
	begin
		next_rd = 8'h00;
		unique case (reg_req_i.addr)
			`TAM_ADDR_FLAGS: next_rd = flags;
			`TAM_ADDR_IRQ_EN: next_rd = irq_en;
			`TAM_ADDR_PIN_CFG: next_rd = pin_cfg;
			`TAM_ADDR_UPPER_HI: next_rd = upper[15:8];
			`TAM_ADDR_UPPER_LO: next_rd = upper[7:0];
			`TAM_ADDR_LOWER_HI: next_rd = lower[15:8];
			`TAM_ADDR_LOWER_LO: next_rd = lower[7:0];
			`TAM_ADDR_RISE: next_rd = rise;
			`TAM_ADDR_FALL: next_rd = fall;
			`TAM_ADDR_SLOPE_CFG: next_rd = slope_cfg;
			`TAM_ADDR_CONV_CTRL: next_rd = conv_ctrl;
			`TAM_ADDR_SLOPE_HI: next_rd = {{7{slope[8]}}, slope[8]};
			`TAM_ADDR_SLOPE_LO: next_rd = slope[7:0];
			default: next_rd = 8'h00;
		endcase
	end

	// Limit registers, reset so that neither alarm trips
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			upper <= `TAM_UPPER_RST;
			lower <= `TAM_LOWER_RST;
		end
		else
		begin
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_UPPER_HI))
				upper[15:8] <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_UPPER_LO))
				upper[7:0] <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_LOWER_HI))
				lower[15:8] <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_LOWER_LO))
				lower[7:0] <= reg_req_i.wdata;
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			irq_en <= `TAM_BYTE_RST;
			pin_cfg <= `TAM_BYTE_RST;
			rise <= `TAM_BYTE_RST;
			fall <= `TAM_BYTE_RST;
			slope_cfg <= `TAM_BYTE_RST;
			conv_ctrl <= `TAM_BYTE_RST;
		end
		else
		begin
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_IRQ_EN))
				irq_en <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_PIN_CFG))
				pin_cfg <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_RISE))
				rise <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_FALL))
				fall <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_SLOPE_CFG))
				slope_cfg <= reg_req_i.wdata;
			if (hit(reg_req_i.wr, reg_req_i.addr, `TAM_ADDR_CONV_CTRL))
				conv_ctrl <= reg_req_i.wdata;
		end
	end

	// Status, interrupt pin and read data
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			flags <= `TAM_BYTE_RST;
			irq_o <= 1'b0;
			rd_data_o <= 8'h00;
		end
		else
		begin
			flags <= next_flags;
			irq_o <= next_irq;
			// Captured before the read clear takes effect
			if (reg_req_i.rd)
				rd_data_o <= next_rd;
		end
	end

	// Slope result and history bookkeeping
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			slope <= `TAM_SLOPE_RST;
			wp <= 6'h00;
			fill <= 7'h00;
		end
		else if (!roc_en)
		begin
			// Slope kept, window restarts when the mode returns
			fill <= 7'h00;
		end
		else if (conv_i.valid)
		begin
			wp <= wp + 6'h01;
			if (fill != 7'h40)
				fill <= fill + 7'h01;
			if (enough)
				slope <= new_slope;
		end
	end

	// History store has no reset; fill count guards stale slots
	always_ff @(posedge clk_i)
	begin
		if (roc_en && conv_i.valid)
			hist[wp] <= conv_i.temp;
	end

	// High result sets the high flag next cycle
	a_high_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		conv_i.valid && above |=> flags[`TAM_BIT_HIGH])
		else $error("high flag not set");

	// Latched low flag set by a low result
	a_low_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		conv_i.valid && below && alert_mode == TAM_ALERT_LATCH |=> flags[`TAM_BIT_LOW])
		else $error("low flag not set");

	// Hysteretic mode keeps low flag at zero
	a_low_zero_hyst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_mode == TAM_ALERT_HYST |=> !flags[`TAM_BIT_LOW])
		else $error("low flag set in hysteretic mode");

	// Latched flag survives a clean result
	a_flag_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_mode == TAM_ALERT_LATCH && flags[`TAM_BIT_HIGH] && !status_rd
		|=> flags[`TAM_BIT_HIGH])
		else $error("latched flag lost without read");

	// Read clears everything in latched mode
	a_read_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		status_rd && !conv_i.valid && alert_mode == TAM_ALERT_LATCH
		|=> flags[`TAM_BIT_FALL:`TAM_BIT_HIGH] == 4'h0)
		else $error("status read did not clear");

	// Read leaves hysteretic high flag alone
	a_hyst_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_mode == TAM_ALERT_HYST && status_rd && flags[`TAM_BIT_HIGH]
		&& !(conv_i.valid && below) |=> flags[`TAM_BIT_HIGH])
		else $error("read cleared hysteretic alert");

	// Low result releases hysteretic alert
	a_hyst_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_mode == TAM_ALERT_HYST && conv_i.valid && below && !above
		|=> !flags[`TAM_BIT_HIGH] ##1 (!irq_o || |irq_en[`TAM_BIT_FALL:`TAM_BIT_LOW]
		|| !$stable(irq_en) || flags[`TAM_BIT_HIGH]))
		else $error("hysteretic alert not released");

	// Enabled high flag drives the pin
	a_irq_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flags[`TAM_BIT_HIGH] && irq_en[`TAM_BIT_HIGH] && $stable(irq_en) |-> irq_o)
		else $error("enabled high flag without interrupt");

	// Enabled fall flag drives the pin
	a_irq_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flags[`TAM_BIT_FALL] && irq_en[`TAM_BIT_FALL] && $stable(irq_en) |-> irq_o)
		else $error("enabled fall flag without interrupt");

	// No slope before the window has filled
	a_slope_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!enough |=> $stable(slope))
		else $error("slope written early");

	// Disabled slope mode freezes the result
	a_roc_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!roc_en |=> $stable(slope))
		else $error("slope changed while disabled");

	// Fast rise sets its flag
	a_rise_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		slope_upd && rise_hit |=> flags[`TAM_BIT_RISE] && slope == $past(new_slope))
		else $error("rise flag or slope missing");

	// Fast fall sets its flag and stores the slope
	a_fall_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		slope_upd && fall_hit |=> flags[`TAM_BIT_FALL] && slope == $past(new_slope))
		else $error("fall flag or slope missing");

	// Enabled rise flag drives the pin
	a_irq_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flags[`TAM_BIT_RISE] && irq_en[`TAM_BIT_RISE] && $stable(irq_en) |-> irq_o)
		else $error("enabled rise flag without interrupt");

	// Enabled low flag drives the pin
	a_irq_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flags[`TAM_BIT_LOW] && irq_en[`TAM_BIT_LOW] && $stable(irq_en) |-> irq_o)
		else $error("enabled low flag without interrupt");

	// Masked flags keep the pin quiet; a mask change shows a cycle late
	a_irq_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$stable(irq_en)
		&& (flags[`TAM_BIT_FALL:`TAM_BIT_HIGH] & irq_en[`TAM_BIT_FALL:`TAM_BIT_HIGH]) == 4'h0
		|-> !irq_o)
		else $error("interrupt without an enabled flag");

	// Latched low flag survives a clean result
	a_low_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_mode == TAM_ALERT_LATCH && flags[`TAM_BIT_LOW] && !status_rd
		|=> flags[`TAM_BIT_LOW])
		else $error("latched low flag lost without read");

	// Status read clears both slope flags in either alert mode
	a_slope_rd_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		status_rd && !slope_upd |=> !flags[`TAM_BIT_RISE] && !flags[`TAM_BIT_FALL])
		else $error("slope flags survived status read");

	// Hysteretic alert holds until a low result arrives
	a_hyst_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_mode == TAM_ALERT_HYST && flags[`TAM_BIT_HIGH] && !(conv_i.valid && below)
		|=> flags[`TAM_BIT_HIGH])
		else $error("hysteretic alert dropped early");

	// History pointer moves only on a counted sample
	a_wp_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!(roc_en && conv_i.valid) |=> $stable(wp))
		else $error("history pointer moved without a sample");

	// Leaving slope mode restarts the window, so stale slots are never used
	a_fill_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!roc_en |=> fill == 7'h00)
		else $error("window fill kept while disabled");

	// Oversized rise clips to the largest slope code
	a_slope_sat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		slope_upd && scaled > $signed(`TAM_SLOPE_MAX) |=> slope == 9'h0FF)
		else $error("slope not clipped");

	// Upper slope byte is pure sign extension
	a_slope_sign: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit(reg_req_i.rd, reg_req_i.addr, `TAM_ADDR_SLOPE_HI)
		|=> rd_data_o == {8{$past(slope[8])}})
		else $error("slope upper byte not sign extension");

endmodule

// ==== bench/tam_host_model.sv ====
// Host controller model issuing byte register accesses
`timescale 1ns/100ps

module tam_host_model (
	// Clock
	input wire logic clk_i,
	// Register port towards the alarm block
	output tam_pkg::tam_reg_req_t reg_req_o,
	input wire logic [7:0] rd_data_i
);
	import tam_pkg::*;

	// Bus idle from time zero
	initial reg_req_o = '0;

	// One byte access, held for exactly one sampling edge
	// Released lines carry inverted values so stale data cannot pass
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		reg_req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_i);
		reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
		q = rd_data_i;
	endtask
endmodule

// ==== bench/temp_alarm_slope_monitor_test.sv ====
// Self-checking bench for the threshold and slope alarm block
`timescale 1ns/100ps
`include "tam_regs.svh"

module temp_alarm_slope_monitor_test;
	import tam_pkg::*;

	logic clk_i;
	logic rst_n_i;
	tam_reg_req_t reg_req;
	logic [7:0] rd_data;
	tam_conv_t conv;
	logic irq;
	int n_errors;
	int num_checks;
	int cycles;
	logic [7:0] q;

	tam_slope_monitor u_tam_slope_monitor (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.reg_req_i(reg_req),
		.rd_data_o(rd_data),
		.conv_i(conv),
		.irq_o(irq)
	);

	tam_host_model u_tam_host_model (
		.clk_i(clk_i),
		.reg_req_o(reg_req),
		.rd_data_i(rd_data)
	);

	// Free running 50 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Verdict and end of run
	task automatic wrap_up;
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			wrap_up;
		end
	end

	// Single compare point
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bus and conversion helpers
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_tam_host_model.access(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		u_tam_host_model.access(1'b0, a, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask

	task automatic ci(input logic e);
		chk({15'h0000, irq}, {15'h0000, e});
	endtask

	// One-cycle result pulse; flags settle at the following edge
	task automatic cvt(input logic [15:0] t);
		@(posedge clk_i);
		conv <= '{valid: 1'b1, temp: t};
		@(posedge clk_i);
		conv <= '{valid: 1'b0, temp: ~t};
		#1;
	endtask

	// Fresh reset so every scenario starts alone
	task automatic rst;
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
	endtask

	// Upper limit +256, lower limit lo_hi times 256 (-256 for lo_hi FF)
	task automatic limits(input logic [7:0] lo_hi);
		wr(`TAM_ADDR_UPPER_HI, 8'h01);
		wr(`TAM_ADDR_UPPER_LO, 8'h00);
		wr(`TAM_ADDR_LOWER_HI, lo_hi);
		wr(`TAM_ADDR_LOWER_LO, 8'h00);
	endtask

	// Reset values, extremes never trip
	task automatic t_reset;
		rst;
		rdc(`TAM_ADDR_UPPER_HI, 8'h7F);
		rdc(`TAM_ADDR_UPPER_LO, 8'hFF);
		rdc(`TAM_ADDR_LOWER_HI, 8'h80);
		rdc(`TAM_ADDR_LOWER_LO, 8'h00);
		rdc(8'h40, 8'h00);
		wr(`TAM_ADDR_IRQ_EN, 8'h0C);
		cvt(16'h7FFF);
		cvt(16'h8000);
		ci(1'b0);
		rdc(`TAM_ADDR_FLAGS, 8'h00);
	endtask

	// Latched mode: strict, signed, sticky until read
	task automatic t_latch;
		rst;
		wr(`TAM_ADDR_IRQ_EN, 8'h0C);
		limits(8'hFF);
		cvt(16'h0100);
		cvt(16'hFF00);
		ci(1'b0);
		cvt(16'h0101);
		ci(1'b1);
		cvt(16'h0000);
		ci(1'b1);
		rdc(`TAM_ADDR_FLAGS, 8'h04);
		ci(1'b0);
		cvt(16'hFEFF);
		ci(1'b1);
		rdc(`TAM_ADDR_FLAGS, 8'h08);
		rdc(`TAM_ADDR_FLAGS, 8'h00);
		// Host raises the limit, clears, then reconverts
		cvt(16'h0200);
		wr(`TAM_ADDR_UPPER_HI, 8'h7F);
		rdc(`TAM_ADDR_FLAGS, 8'h04);
		wr(`TAM_ADDR_IRQ_EN, 8'h00);
		cvt(16'h0200);
		ci(1'b0);
		rdc(`TAM_ADDR_FLAGS, 8'h00);
	endtask

	// Hysteretic mode: reads keep the high flag, low limit releases
	task automatic t_hyst;
		rst;
		wr(`TAM_ADDR_IRQ_EN, 8'h0C);
		wr(`TAM_ADDR_CONV_CTRL, 8'h06);
		limits(8'h00);
		cvt(16'h0101);
		ci(1'b1);
		rdc(`TAM_ADDR_FLAGS, 8'h04);
		ci(1'b1);
		cvt(16'h0000);
		ci(1'b1);
		cvt(16'hFFFF);
		ci(1'b0);
		rdc(`TAM_ADDR_FLAGS, 8'h00);
	endtask

	// Slope with a two-sample window, gated by the pin trigger
	task automatic t_slope;
		rst;
		wr(`TAM_ADDR_IRQ_EN, 8'h10);
		wr(`TAM_ADDR_RISE, 8'h0A);
		wr(`TAM_ADDR_FALL, 8'h0A);
		wr(`TAM_ADDR_SLOPE_CFG, 8'h08);
		cvt(16'h0000);
		wr(`TAM_ADDR_PIN_CFG, 8'h80);
		cvt(16'h0064);
		rdc(`TAM_ADDR_SLOPE_LO, 8'h00);
		cvt(16'h0078);
		ci(1'b1);
		rdc(`TAM_ADDR_SLOPE_HI, 8'h00);
		rdc(`TAM_ADDR_SLOPE_LO, 8'h14);
		cvt(16'h0082);
		rdc(`TAM_ADDR_FLAGS, 8'h10);
		ci(1'b0);
		cvt(16'h0064);
		ci(1'b0);
		rdc(`TAM_ADDR_SLOPE_HI, 8'hFF);
		rdc(`TAM_ADDR_SLOPE_LO, 8'hE2);
		rdc(`TAM_ADDR_FLAGS, 8'h20);
		wr(`TAM_ADDR_PIN_CFG, 8'h00);
		cvt(16'h1000);
		rdc(`TAM_ADDR_SLOPE_LO, 8'hE2);
		rdc(`TAM_ADDR_FLAGS, 8'h00);
	endtask

	// Nine-sample window under autonomous mode, ramp of 8 per sample
	task automatic t_window;
		rst;
		wr(`TAM_ADDR_CONV_CTRL, 8'h02);
		wr(`TAM_ADDR_SLOPE_CFG, 8'h0B);
		for (int i = 0; i < 9; i++)
		begin
			cvt(16'(i * 8));
			if (i == 7)
				rdc(`TAM_ADDR_SLOPE_LO, 8'h00);
		end
		rdc(`TAM_ADDR_SLOPE_LO, 8'h08);
	endtask

	// Widest window falling 64 per sample, then a clipping jump
	task automatic t_wide;
		rst;
		wr(`TAM_ADDR_IRQ_EN, 8'h20);
		wr(`TAM_ADDR_FALL, 8'h3F);
		wr(`TAM_ADDR_CONV_CTRL, 8'h02);
		wr(`TAM_ADDR_SLOPE_CFG, 8'h0F);
		for (int i = 0; i < 65; i++)
		begin
			cvt(16'(-64 * i));
			if (i == 63)
			begin
				ci(1'b0);
				rdc(`TAM_ADDR_SLOPE_LO, 8'h00);
			end
		end
		ci(1'b1);
		rdc(`TAM_ADDR_SLOPE_HI, 8'hFF);
		rdc(`TAM_ADDR_SLOPE_LO, 8'hC0);
		rdc(`TAM_ADDR_FLAGS, 8'h20);
		cvt(16'h7000);
		ci(1'b0);
		rdc(`TAM_ADDR_SLOPE_HI, 8'h00);
		rdc(`TAM_ADDR_SLOPE_LO, 8'hFF);
		rdc(`TAM_ADDR_FLAGS, 8'h10);
	endtask

	// Main sequence
	initial
	begin
		rst_n_i = 1'b0;
		conv = '0;
		n_errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset;
		t_latch;
		t_hyst;
		t_slope;
		t_window;
		t_wide;
		wrap_up;
	end
endmodule
